// [hdl/sad_selector.v]
// One display's status condition selector and alternation
`timescale 1ns/100ps
`include "sad_defines.vh"
module sad_selector (
  input wire aclk,
  input wire aresetn,
  input wire [`SAD_SEL_W-1:0] sel,
  input wire view_ok,
  input wire phase,
  input wire manual_mode,
  input wire reset_state,
  input wire [3:0] alarm,
  input wire element_break_alarm,
  input wire ssr_short_alarm,
  input wire standby_state,
  output reg show_tag_q,
  output reg [`SAD_TAG_W-1:0] tag_q,
  output reg cond_q
);
  reg cond;
  reg [`SAD_TAG_W-1:0] tag;

  // ----------------------------------------
  // Condition decode
  // ----------------------------------------
  always @* begin
    cond = 1'b0;
    tag = `SAD_TAG_NONE;
    case (sel)
      `SAD_SEL_OFF: begin
        cond = 1'b0;
      end
      `SAD_SEL_MANUAL: begin
        cond = manual_mode;
        tag = `SAD_TAG_HAND;
      end
      `SAD_SEL_RESET: begin
        cond = reset_state;
        tag = `SAD_TAG_RESET;
      end
      `SAD_SEL_ALARM1: begin
        cond = alarm[0];
        tag = `SAD_TAG_ALARM1;
      end
      `SAD_SEL_ALARM2: begin
        cond = alarm[1];
        tag = `SAD_TAG_ALARM2;
      end
      `SAD_SEL_ALARM3: begin
        cond = alarm[2];
        tag = `SAD_TAG_ALARM3;
      end
      `SAD_SEL_ALARM4: begin
        cond = alarm[3];
        tag = `SAD_TAG_ALARM4;
      end
      `SAD_SEL_ANY_ALARM: begin
        cond = |alarm;
        tag = `SAD_TAG_ANY_ALARM;
      end
      `SAD_SEL_HEATER: begin
        cond = element_break_alarm | ssr_short_alarm;
        tag = `SAD_TAG_HEATER;
      end
      `SAD_SEL_STANDBY: begin
        cond = standby_state;
        tag = `SAD_TAG_STANDBY;
      end
      default: begin
        cond = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      show_tag_q <= 1'b0;
      tag_q <= `SAD_TAG_NONE;
      cond_q <= 1'b0;
    end else begin
      cond_q <= cond;
      tag_q <= cond ? tag : `SAD_TAG_NONE;
      show_tag_q <= cond & view_ok & phase;
    end
  end
endmodule

// [hdl/sad_timebase.v]
// Free-running half-second phase generator
`timescale 1ns/100ps
`include "sad_defines.vh"
module sad_timebase #(
  parameter HALF_TICKS = `SAD_HALF_TICKS,
  parameter CNT_W = 26
) (
  input wire aclk,
  input wire aresetn,
  output reg phase_q,
  output reg flip_q
);
  reg [CNT_W-1:0] cnt_q;
  wire last = (cnt_q == HALF_TICKS[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1});

  // ----------------------------------------
  // Divider, never stopped by the selection
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= {CNT_W{1'b0}};
      phase_q <= 1'b0;
      flip_q <= 1'b0;
    end else begin
      flip_q <= last;
      if (last) begin
        cnt_q <= {CNT_W{1'b0}};
        phase_q <= ~phase_q;
      end else begin
        cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// [hdl/sad_top.v]
// Status alternating display top with AXI4-Lite registers
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "sad_defines.vh"
module sad_top #(
  parameter HALF_TICKS = `SAD_HALF_TICKS
) (
  input wire aclk,
  input wire aresetn,
  input wire [`SAD_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`SAD_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire pv_view,
  input wire pv_sp_item_view,
  input wire sv_view,
  input wire [1:0] sv_content,
  input wire prog_end_active,
  input wire prog_end_alt,
  input wire manual_mode,
  input wire reset_state,
  input wire [3:0] alarm,
  input wire element_break_alarm,
  input wire ssr_short_alarm,
  input wire standby_state,
  output reg pv_show_tag_q,
  output reg [`SAD_TAG_W-1:0] pv_tag_q,
  output reg sv_show_tag_q,
  output reg [`SAD_TAG_W-1:0] sv_tag_q,
  output reg sv_prog_end_alt_q,
  output reg [1:0] sv_content_q
);
  reg [`SAD_SEL_W-1:0] pv_sel_q;
  reg [`SAD_SEL_W-1:0] sv_sel_q;
  reg [15:0] ticks_q;
  reg have_aw_q;
  reg have_w_q;
  reg [`SAD_ADDR_W-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire phase;
  wire flip;
  wire pv_tag_on;
  wire sv_tag_on;
  wire pv_cond;
  wire sv_cond;
  wire [`SAD_TAG_W-1:0] pv_tag;
  wire [`SAD_TAG_W-1:0] sv_tag;

  // ----------------------------------------
  // Address decode shared by both channels
  // ----------------------------------------
  function sad_mapped;
    input [`SAD_ADDR_W-1:0] addr;
    begin
      sad_mapped = (addr == `SAD_REG_PV_SEL) || (addr == `SAD_REG_SV_SEL) || (addr == `SAD_REG_STATUS) ||
        (addr == `SAD_REG_TICKS);
    end
  endfunction

  // ----------------------------------------
  // Timebase and the two selectors
  // ----------------------------------------
  sad_timebase #(.HALF_TICKS(HALF_TICKS)) u_tb (
    .aclk(aclk),
    .aresetn(aresetn),
    .phase_q(phase),
    .flip_q(flip)
  );

  sad_selector u_pv (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel(pv_sel_q),
    .view_ok(pv_view | pv_sp_item_view),
    .phase(phase),
    .manual_mode(manual_mode),
    .reset_state(reset_state),
    .alarm(alarm),
    .element_break_alarm(element_break_alarm),
    .ssr_short_alarm(ssr_short_alarm),
    .standby_state(standby_state),
    .show_tag_q(pv_tag_on),
    .tag_q(pv_tag),
    .cond_q(pv_cond)
  );

  // Same selector module gives the second display identical choices
  sad_selector u_sv (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel(sv_sel_q),
    .view_ok(sv_view),
    .phase(phase),
    .manual_mode(manual_mode),
    .reset_state(reset_state),
    .alarm(alarm),
    .element_break_alarm(element_break_alarm),
    .ssr_short_alarm(ssr_short_alarm),
    .standby_state(standby_state),
    .show_tag_q(sv_tag_on),
    .tag_q(sv_tag),
    .cond_q(sv_cond)
  );

  // ----------------------------------------
  // Display outputs
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      pv_show_tag_q <= 1'b0;
      pv_tag_q <= `SAD_TAG_NONE;
      sv_show_tag_q <= 1'b0;
      sv_tag_q <= `SAD_TAG_NONE;
      sv_prog_end_alt_q <= 1'b0;
      sv_content_q <= `SAD_SV_SETPOINT;
      ticks_q <= 16'h0000;
    end else begin
      pv_show_tag_q <= pv_tag_on;
      pv_tag_q <= pv_tag;
      sv_show_tag_q <= sv_tag_on;
      sv_tag_q <= sv_tag;
      sv_content_q <= sv_content;
      // Program end display only when no tag alternation is running
      sv_prog_end_alt_q <= prog_end_active & prog_end_alt & ~(sv_cond & sv_view);
      if (flip) begin
        ticks_q <= ticks_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SAD_RESP_OKAY;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      awaddr_q <= {`SAD_ADDR_W{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      pv_sel_q <= `SAD_SEL_OFF;
      sv_sel_q <= `SAD_SEL_OFF;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (have_aw_q && have_w_q && !s_axi_bvalid) begin
        have_aw_q <= 1'b0;
        have_w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= sad_mapped(awaddr_q) ? `SAD_RESP_OKAY : `SAD_RESP_SLVERR;
        case (awaddr_q)
          `SAD_REG_PV_SEL: begin
            if (wstrb_q[0]) begin
              pv_sel_q <= wdata_q[`SAD_SEL_W-1:0];
            end
          end
          `SAD_REG_SV_SEL: begin
            if (wstrb_q[0]) begin
              sv_sel_q <= wdata_q[`SAD_SEL_W-1:0];
            end
          end
          default: begin
            // Status, counter and unmapped offsets store nothing
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SAD_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= sad_mapped(s_axi_araddr) ? `SAD_RESP_OKAY : `SAD_RESP_SLVERR;
        case (s_axi_araddr)
          `SAD_REG_PV_SEL: s_axi_rdata <= {28'h0000000, pv_sel_q};
          `SAD_REG_SV_SEL: s_axi_rdata <= {28'h0000000, sv_sel_q};
          `SAD_REG_STATUS: s_axi_rdata <= {22'h000000, phase, sv_prog_end_alt_q, sv_cond, pv_cond,
                                           sv_show_tag_q, pv_show_tag_q, sv_tag_q[1:0], pv_tag_q[1:0]};
          `SAD_REG_TICKS: s_axi_rdata <= {16'h0000, ticks_q};
          default: begin
            s_axi_rdata <= 32'h00000000;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// [inc/sad_defines.vh]
// Constants for the status alternating display block
// Contract
// - While a process-value view is shown and the chosen condition holds, the first display alternates value and tag every half second.
// - The process-value views that alternate include the value and setpoint pair picked as a monitor or setting item.
// - With the selection off no tag is shown and the normal value stays on continuously.
// - The manual selection alternates the hand-control tag while the controller is under manual control.
// - The reset selection alternates the reset tag while operation is in reset status.
// - Each of the four single-alarm selections alternates its own numbered tag only while that alarm output is active.
// - The any-alarm selection alternates the combined alarm tag while alarm one, two, three or four is active.
// - The heater alarm selection alternates the heater fault tag while the element break or the SSR short alarm is active.
// - The standby selection alternates the standby tag while operation is on standby.
// - After reset each display's status selection is off.
// - The second display alternates the setpoint, manual manipulated value or blank with the tag every half second.
// - The second display uses the same choices and condition meanings as the first.
// - On the second display the tag alternation takes priority over the program end output display.
`ifndef SAD_DEFINES_VH
`define SAD_DEFINES_VH

// ----------------------------------------
// AXI4-Lite register map
// ----------------------------------------
`define SAD_ADDR_W 4
`define SAD_REG_PV_SEL 4'h0
`define SAD_REG_SV_SEL 4'h4
`define SAD_REG_STATUS 4'h8
`define SAD_REG_TICKS 4'hC
`define SAD_RESP_OKAY 2'h0
`define SAD_RESP_SLVERR 2'h2

// ----------------------------------------
// Status selection codes
// ----------------------------------------
`define SAD_SEL_W 4
`define SAD_SEL_OFF 4'h0
`define SAD_SEL_MANUAL 4'h1
`define SAD_SEL_RESET 4'h2
`define SAD_SEL_ALARM1 4'h3
`define SAD_SEL_ALARM2 4'h4
`define SAD_SEL_ALARM3 4'h5
`define SAD_SEL_ALARM4 4'h6
`define SAD_SEL_ANY_ALARM 4'h7
`define SAD_SEL_HEATER 4'h8
`define SAD_SEL_STANDBY 4'h9

// ----------------------------------------
// Tag codes on the tag output
// ----------------------------------------
`define SAD_TAG_W 4
`define SAD_TAG_NONE 4'h0
`define SAD_TAG_HAND 4'h1
`define SAD_TAG_RESET 4'h2
`define SAD_TAG_ALARM1 4'h3
`define SAD_TAG_ALARM2 4'h4
`define SAD_TAG_ALARM3 4'h5
`define SAD_TAG_ALARM4 4'h6
`define SAD_TAG_ANY_ALARM 4'h7
`define SAD_TAG_HEATER 4'h8
`define SAD_TAG_STANDBY 4'h9

// ----------------------------------------
// Second display content codes
// ----------------------------------------
`define SAD_SV_SETPOINT 2'h0
`define SAD_SV_MANUAL_MV 2'h1
`define SAD_SV_BLANK 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define SAD_CLK_HZ 100000000
`define SAD_HALF_PERIOD_MS 500
`define SAD_HALF_TICKS ((`SAD_CLK_HZ / 1000) * `SAD_HALF_PERIOD_MS)

`endif

// [sim/sad_status_model.sv]
// Controller status model driving the condition inputs
`timescale 1ns/100ps
module sad_status_model (
  input wire aclk,
  input wire [3:0] cond_code,
  output reg manual_mode = 1'h0,
  output reg reset_state = 1'h0,
  output reg [3:0] alarm = 4'h0,
  output reg element_break_alarm = 1'h0,
  output reg ssr_short_alarm = 1'h0,
  output reg standby_state = 1'h0
);
  // Code 7 raises alarm four alone, code 10 the element break alarm
  always @(posedge aclk) begin
    manual_mode <= cond_code == 4'h1;
    reset_state <= cond_code == 4'h2;
    alarm <= {cond_code == 4'h6 || cond_code == 4'h7, cond_code == 4'h5, cond_code == 4'h4, cond_code == 4'h3};
    element_break_alarm <= cond_code == 4'hA;
    ssr_short_alarm <= cond_code == 4'h8;
    standby_state <= cond_code == 4'h9;
  end
endmodule

// [sim/sad_top_properties.sv]
// Concurrent checks on the status alternating display top
`timescale 1ns/100ps
`include "sad_defines.vh"
module sad_props #(
  parameter HALF_TICKS = `SAD_HALF_TICKS
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire pv_view,
  input wire pv_sp_item_view,
  input wire sv_view,
  input wire prog_end_active,
  input wire prog_end_alt,
  input wire pv_show_tag_q,
  input wire [`SAD_TAG_W-1:0] pv_tag_q,
  input wire sv_show_tag_q,
  input wire [`SAD_TAG_W-1:0] sv_tag_q,
  input wire sv_prog_end_alt_q
);
  reg [31:0] hi_q;
  always @(posedge aclk) begin
    if (!aresetn || !pv_show_tag_q) hi_q <= 32'h0;
    else hi_q <= hi_q + 32'h1;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_pv_view_gate: assert property ((!pv_view && !pv_sp_item_view)[*3] |-> !pv_show_tag_q)
    else $error("first display tag without view");
  a_sv_view_gate: assert property (!sv_view[*3] |-> !sv_show_tag_q)
    else $error("second display tag without view");
  a_pv_tag_code: assert property (pv_show_tag_q |-> pv_tag_q != 4'h0)
    else $error("first display tag shown with no code");
  a_sv_tag_code: assert property (sv_show_tag_q |-> sv_tag_q != 4'h0)
    else $error("second display tag shown with no code");
  a_pv_half_max: assert property (hi_q <= HALF_TICKS)
    else $error("tag half longer than half period");
  a_prog_end_cause: assert property (sv_prog_end_alt_q |-> $past(prog_end_active && prog_end_alt))
    else $error("program end alternation without request");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during response");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready during response");
endmodule
bind sad_top sad_props #(.HALF_TICKS(HALF_TICKS)) u_props (.*);

// [sim/test_status_alternating_display.sv]
// Self-checking bench for the status alternating display
`timescale 1ns/100ps
`include "sad_defines.vh"
module test_status_alternating_display;
  localparam HT = 8;
  reg aclk = 1'h0;
  reg aresetn = 1'h0;
  reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, cond_code = 4'h0, s_axi_wstrb = 4'hF;
  reg [31:0] s_axi_wdata = 32'h0;
  reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  reg pv_view = 1'h0, pv_sp_item_view = 1'h0, sv_view = 1'h0, prog_end_active = 1'h0, prog_end_alt = 1'h0;
  reg [1:0] sv_content = 2'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, manual_mode, reset_state;
  wire element_break_alarm, ssr_short_alarm, standby_state, pv_show_tag_q, sv_show_tag_q, sv_prog_end_alt_q;
  wire [1:0] s_axi_bresp, s_axi_rresp, sv_content_q;
  wire [31:0] s_axi_rdata;
  wire [3:0] alarm, pv_tag_q, sv_tag_q;
  integer n_errors = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer d, i, hi, sel, cc, et;
  reg [31:0] rd;
  reg [1:0] rsp;
  reg [3:0] tg;
  sad_top #(.HALF_TICKS(HT)) dut (.*);
  sad_status_model u_model (.*);
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("unexpected %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] v, output [1:0] r);
    reg pa;
    reg pw;
    begin
      pa = 1'h1;
      pw = 1'h1;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (pa || pw) begin
        @(posedge aclk);
        if (s_axi_awready) pa = 1'h0;
        if (s_axi_wready) pw = 1'h0;
        s_axi_awvalid <= pa;
        s_axi_wvalid <= pw;
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge aclk);
    end
  endtask
  task rdr(input [3:0] a, output [31:0] v);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge aclk);
    end
  endtask
  task watch(input integer n);
    begin
      hi = 0;
      tg = 4'h0;
      repeat (n) begin
        @(posedge aclk);
        if (d ? sv_show_tag_q : pv_show_tag_q) begin
          hi = hi + 1;
          tg = d ? sv_tag_q : pv_tag_q;
        end
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (d = 0; d < 2; d = d + 1) begin
      rdr(d ? 4'h4 : 4'h0, rd);
      chk("sel", 0, rd);
    end
    wr(4'h2, 1, rsp);
    chk("bresp", `SAD_RESP_SLVERR, rsp);
    rdr(4'h2, rd);
    chk("rresp", `SAD_RESP_SLVERR, rsp);
    chk("rdata", 0, rd);
    rdr(4'hC, rd);
    cc = rd;
    repeat (2 * HT - 3) @(posedge aclk);
    rdr(4'hC, rd);
    chk("ticks", cc + 2, rd);
    pv_view <= 1'h1;
    sv_view <= 1'h1;
    sv_content <= `SAD_SV_BLANK;
    for (d = 0; d < 2; d = d + 1) begin
      for (i = 0; i < 12; i = i + 1) begin
        sel = i == 10 ? 8 : i == 11 ? 3 : i;
        cc = i == 0 ? 3 : i == 10 ? 10 : i == 11 ? 4 : i;
        et = i == 0 || i == 11 ? 0 : sel;
        wr(d ? 4'h4 : 4'h0, sel, rsp);
        chk("bresp", `SAD_RESP_OKAY, rsp);
        rdr(d ? 4'h4 : 4'h0, rd);
        chk("rdback", sel, rd);
        cond_code <= cc[3:0];
        repeat (3) @(posedge aclk);
        watch(4 * HT);
        chk("high", et ? 2 * HT : 0, hi);
        chk("tag", et, tg);
        cond_code <= 4'h0;
        repeat (3) @(posedge aclk);
        watch(2 * HT);
        chk("drop", 0, hi);
      end
    end
    d = 0;
    pv_view <= 1'h0;
    pv_sp_item_view <= 1'h1;
    cond_code <= 4'h3;
    prog_end_active <= 1'h1;
    prog_end_alt <= 1'h1;
    repeat (3) @(posedge aclk);
    watch(4 * HT);
    chk("high", 2 * HT, hi);
    chk("pe", 0, sv_prog_end_alt_q);
    chk("svc", `SAD_SV_BLANK, sv_content_q);
    pv_sp_item_view <= 1'h0;
    repeat (3) @(posedge aclk);
    watch(4 * HT);
    chk("high", 0, hi);
    cond_code <= 4'h0;
    repeat (4) @(posedge aclk);
    chk("pe", 1, sv_prog_end_alt_q);
    report_and_stop;
  end
endmodule
